/* include/rtm_defs.svh */
// Register offsets, reset values, bit positions and timing figures of the temperature monitor.
`ifndef RTM_DEFS_SVH
`define RTM_DEFS_SVH
`define RTM_A_CTRL 8'h00
`define RTM_A_RATE 8'h04
`define RTM_A_ONESHOT 8'h08
`define RTM_A_OFFSET 8'h0c
`define RTM_A_CRIT 8'h10
`define RTM_A_OT 8'h14
`define RTM_A_HYST 8'h18
`define RTM_A_MASK 8'h1c
`define RTM_A_REMOTE 8'h20
`define RTM_A_LOCAL 8'h24
`define RTM_A_STATUS 8'h28
`define RTM_A_INT_ST 8'h2c
`define RTM_A_INT_CLR 8'h30
`define RTM_A_INT_EN 8'h34
`define RTM_RST_CTRL 6'h00
`define RTM_RST_RATE 8'h0f
`define RTM_RST_CRIT 8'h55
`define RTM_RST_OT 8'h46
`define RTM_RST_HYST 8'h0a
`define RTM_EV_CONV 0
`define RTM_EV_CRIT 1
`define RTM_EV_OT 2
`define RTM_MK_RCRIT 0
`define RTM_MK_LCRIT 1
`define RTM_MK_ROT 2
`define RTM_MK_LOT 3
`define RTM_FRAC_BITS 3
`define RTM_SYNC_FILL 2'h3
`define RTM_SGN_MIN 13'sh1c00
`define RTM_SGN_MAX 13'sh03ff
`define RTM_UNS_MAX 13'sh07ff
`define RTM_CLK_NS 25
`define RTM_TICK_NS 62500000
`define RTM_TOUT_NS 25000000
`define RTM_RESP_OKAY 2'h0
`define RTM_RESP_SLVERR 2'h2
`endif

/* include/rtm_pkg.sv */
// Types shared by the temperature monitor design.
package rtm_pkg;
	typedef logic signed [12:0] rtm_temp_t;
	typedef struct packed {
		logic [1:0] filt_level;
		logic pin_is_overtemp;
		logic diode_model;
		logic unsigned_fmt;
		logic standby;
	} rtm_cfg_t;
	typedef enum logic {
		st_idle,
		st_conv
	} rtm_state_t;
endpackage : rtm_pkg

/* rtl/rtm_monitor.sv */
// Conversion control, limit comparison, alert pins and AXI4-Lite registers of the monitor.
// Functional notes
// - Unmasked channel above limit asserts its output.
// - Output levels readable in the status register.
// - One shared hysteresis applies to every limit.
// - Standby stops conversions; one-shot write converts once.
// - Signed or unsigned reporting format.
// - Eleven-bit results for both channels.
// - Shared pin is three-level address input first.
// - Shared pin as overtemp output: open-drain, low.
// - Critical alert is open-drain active low.
// - Configurable filter on remote channel only.
// - Diode model bit selects remote characteristics.
// - Offset register corrects remote results.
// - Conversion interval set by rate register.
// - Bus timeout drops a half-delivered write.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "rtm_defs.svh"
module rtm_monitor import rtm_pkg::*; #(
	parameter int TW = 12,
	parameter int TICK_CYC = `RTM_TICK_NS / `RTM_CLK_NS,
	parameter int TOUT_CYC = (`RTM_TOUT_NS + `RTM_CLK_NS - 1) / `RTM_CLK_NS
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog front end
	output logic o_conv_start,
	output logic o_diode_model,
	input wire logic i_conv_done,
	input wire logic signed [TW-1:0] i_remote_raw,
	input wire logic signed [TW-1:0] i_local_raw,
	// Pins: shared pin input is the three-level comparator pair {above_high, above_low}
	input wire logic [1:0] i_overtemp_or_addr_pin,
	output logic o_overtemp_or_addr_pin,
	output logic o_overtemp_or_addr_pin_oe_b,
	output logic o_critical_alert_out,
	output logic o_critical_alert_out_oe_b,
	output logic [1:0] o_addr_select_in,
	// Interrupt
	output logic o_irq
);
	rtm_cfg_t cfg_r;
	rtm_state_t state_r;
	logic [7:0] rate_r, crit_lim_r, ot_lim_r, hyst_r, ivl_cnt_r;
	logic [10:0] off_r, rem_res_r, loc_res_r;
	logic [3:0] mask_r;
	logic [2:0] int_st_r, int_en_r, ev;
	logic crit_r, ot_r, crit_nxt, ot_nxt, conv_start_r, addr_done_r;
	rtm_temp_t rem_t_r, loc_t_r, filt_r, rem_corr;
	logic [$clog2(TICK_CYC)-1:0] tick_cnt_r;
	logic [$clog2(TOUT_CYC+1)-1:0] tout_cnt_r;
	logic [1:0] pin_s1_r, pin_s2_r, pin_s3_r, fill_r;
	logic aw_ok_r, w_ok_r, bvalid_r, rvalid_r, wr_go, wr_map;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r, rd_mux, rdata_r, wv;
	logic [3:0] w_strb_r;
	logic [1:0] bresp_r, rresp_r;
	logic tick, interval_hit, oneshot_wr;

	function automatic logic is_mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a <= `RTM_A_INT_EN);
	endfunction : is_mapped

	function automatic logic over_lim(input rtm_temp_t t, input logic [7:0] lim);
		return t > $signed({2'h0, lim, 3'h0});
	endfunction : over_lim

	function automatic logic below_hyst(input rtm_temp_t t, input logic [7:0] lim,
		input logic [7:0] h);
		return t < ($signed({2'h0, lim, 3'h0}) - $signed({2'h0, h, 3'h0}));
	endfunction : below_hyst

	function automatic logic [10:0] to_fmt(input rtm_temp_t t, input logic uns);
		if (uns) begin
			if (t < 0) return 11'h000;
			if (t > `RTM_UNS_MAX) return 11'h7ff;
		end else begin
			if (t < `RTM_SGN_MIN) return 11'h400;
			if (t > `RTM_SGN_MAX) return 11'h3ff;
		end
		return t[10:0];
	endfunction : to_fmt

	// Shared pin: three flip-flops, value taken once stages two and three agree.
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pin_s1_r <= 2'h0;
			pin_s2_r <= 2'h0;
			pin_s3_r <= 2'h0;
		end else begin
			pin_s1_r <= i_overtemp_or_addr_pin;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			addr_done_r <= 1'b0;
			fill_r <= 2'h0;
			o_addr_select_in <= 2'h0;
		end else if (fill_r != `RTM_SYNC_FILL) begin
			// The reset zeros in the stages agree too, so wait until the pin has filled them.
			fill_r <= fill_r + 2'h1;
		end else if (!addr_done_r && pin_s2_r == pin_s3_r) begin
			addr_done_r <= 1'b1;
			o_addr_select_in <= pin_s3_r[1] ? 2'h2 : (pin_s3_r[0] ? 2'h1 : 2'h0);
		end
	end

	// Conversion timebase: one tick per sixteenth of a second, interval of rate+1 ticks.
	assign tick = tick_cnt_r == ($clog2(TICK_CYC))'(TICK_CYC - 1);
	assign interval_hit = tick && ivl_cnt_r >= rate_r;
	assign oneshot_wr = wr_go && wr_map && aw_addr_r == `RTM_A_ONESHOT;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			tick_cnt_r <= '0;
			ivl_cnt_r <= 8'h00;
		end else begin
			tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
			if (interval_hit) ivl_cnt_r <= 8'h00;
			else if (tick) ivl_cnt_r <= ivl_cnt_r + 8'h01;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_r <= st_idle;
			conv_start_r <= 1'b0;
		end else begin
			conv_start_r <= 1'b0;
			case (state_r)
				st_idle: begin
					if ((!cfg_r.standby && interval_hit) || (cfg_r.standby && oneshot_wr)) begin
						conv_start_r <= 1'b1;
						state_r <= st_conv;
					end
				end
				st_conv: begin
					if (i_conv_done) state_r <= st_idle;
				end
				default: state_r <= st_idle;
			endcase
		end
	end

	assign o_conv_start = conv_start_r;
	assign o_diode_model = cfg_r.diode_model;

	// Offset then filter on the remote path; the local path is taken as is.
	assign rem_corr = rtm_temp_t'(i_remote_raw) + rtm_temp_t'($signed(off_r));

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			filt_r <= '0;
			rem_t_r <= '0;
			loc_t_r <= '0;
			rem_res_r <= 11'h000;
			loc_res_r <= 11'h000;
		end else if (state_r == st_conv && i_conv_done) begin
			filt_r <= rtm_temp_t'(filt_r + ((rem_corr - filt_r) >>> cfg_r.filt_level));
			rem_t_r <= rtm_temp_t'(filt_r + ((rem_corr - filt_r) >>> cfg_r.filt_level));
			loc_t_r <= rtm_temp_t'(i_local_raw);
			rem_res_r <= to_fmt(rtm_temp_t'(filt_r + ((rem_corr - filt_r) >>> cfg_r.filt_level)),
				cfg_r.unsigned_fmt);
			loc_res_r <= to_fmt(rtm_temp_t'(i_local_raw), cfg_r.unsigned_fmt);
		end
	end

	// Alert comparison with shared hysteresis on release.
	always_comb begin
		crit_nxt = (!mask_r[`RTM_MK_RCRIT] && over_lim(rem_t_r, crit_lim_r)) ||
			(!mask_r[`RTM_MK_LCRIT] && over_lim(loc_t_r, crit_lim_r));
		if (crit_r) crit_nxt = !((mask_r[`RTM_MK_RCRIT] || below_hyst(rem_t_r, crit_lim_r, hyst_r)) &&
			(mask_r[`RTM_MK_LCRIT] || below_hyst(loc_t_r, crit_lim_r, hyst_r)));
		ot_nxt = (!mask_r[`RTM_MK_ROT] && over_lim(rem_t_r, ot_lim_r)) ||
			(!mask_r[`RTM_MK_LOT] && over_lim(loc_t_r, ot_lim_r));
		if (ot_r) ot_nxt = !((mask_r[`RTM_MK_ROT] || below_hyst(rem_t_r, ot_lim_r, hyst_r)) &&
			(mask_r[`RTM_MK_LOT] || below_hyst(loc_t_r, ot_lim_r, hyst_r)));
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			crit_r <= 1'b0;
			ot_r <= 1'b0;
		end else begin
			crit_r <= crit_nxt;
			ot_r <= ot_nxt;
		end
	end

	assign o_critical_alert_out = 1'b0;
	assign o_critical_alert_out_oe_b = !crit_r;
	assign o_overtemp_or_addr_pin = 1'b0;
	assign o_overtemp_or_addr_pin_oe_b = !(cfg_r.pin_is_overtemp && ot_r);

	// Interrupt status: a new event wins over a clear in the same cycle.
	assign ev = {ot_nxt && !ot_r, crit_nxt && !crit_r, state_r == st_conv && i_conv_done};

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) int_st_r <= 3'h0;
		else if (wr_go && wr_map && aw_addr_r == `RTM_A_INT_CLR) int_st_r <= (int_st_r & ~wv[2:0]) | ev;
		else int_st_r <= int_st_r | ev;
	end

	assign o_irq = |(int_st_r & int_en_r);

	// AXI4-Lite write path; address and data are taken in either order.
	assign s_axi_awready = !aw_ok_r && !bvalid_r;
	assign s_axi_wready = !w_ok_r && !bvalid_r;
	assign wr_go = aw_ok_r && w_ok_r && !bvalid_r;
	assign wr_map = is_mapped(aw_addr_r);
	assign wv = {w_strb_r[3] ? w_data_r[31:24] : 8'h00, w_strb_r[2] ? w_data_r[23:16] : 8'h00,
		w_strb_r[1] ? w_data_r[15:8] : 8'h00, w_strb_r[0] ? w_data_r[7:0] : 8'h00};

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `RTM_RESP_OKAY;
			tout_cnt_r <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_ok_r <= 1'b0;
				w_ok_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= wr_map ? `RTM_RESP_OKAY : `RTM_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
			// A half-delivered write is dropped after the bus timeout.
			if (aw_ok_r ^ w_ok_r) begin
				tout_cnt_r <= tout_cnt_r + 1'b1;
				if (tout_cnt_r == ($clog2(TOUT_CYC+1))'(TOUT_CYC - 1)) begin
					aw_ok_r <= 1'b0;
					w_ok_r <= 1'b0;
					tout_cnt_r <= '0;
				end
			end else begin
				tout_cnt_r <= '0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cfg_r <= `RTM_RST_CTRL;
			rate_r <= `RTM_RST_RATE;
			off_r <= 11'h000;
			crit_lim_r <= `RTM_RST_CRIT;
			ot_lim_r <= `RTM_RST_OT;
			hyst_r <= `RTM_RST_HYST;
			mask_r <= 4'h0;
			int_en_r <= 3'h0;
		end else if (wr_go && wr_map) begin
			case (aw_addr_r)
				`RTM_A_CTRL: cfg_r <= wv[5:0];
				`RTM_A_RATE: rate_r <= wv[7:0];
				`RTM_A_OFFSET: off_r <= wv[10:0];
				`RTM_A_CRIT: crit_lim_r <= wv[7:0];
				`RTM_A_OT: ot_lim_r <= wv[7:0];
				`RTM_A_HYST: hyst_r <= wv[7:0];
				`RTM_A_MASK: mask_r <= wv[3:0];
				`RTM_A_INT_EN: int_en_r <= wv[2:0];
				default: ;
			endcase
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// AXI4-Lite read path.
	always_comb begin
		rd_mux = 32'h0;
		case (s_axi_araddr)
			`RTM_A_CTRL: rd_mux = {26'h0, cfg_r};
			`RTM_A_RATE: rd_mux = {24'h0, rate_r};
			`RTM_A_OFFSET: rd_mux = {21'h0, off_r};
			`RTM_A_CRIT: rd_mux = {24'h0, crit_lim_r};
			`RTM_A_OT: rd_mux = {24'h0, ot_lim_r};
			`RTM_A_HYST: rd_mux = {24'h0, hyst_r};
			`RTM_A_MASK: rd_mux = {28'h0, mask_r};
			`RTM_A_REMOTE: rd_mux = {21'h0, rem_res_r};
			`RTM_A_LOCAL: rd_mux = {21'h0, loc_res_r};
			`RTM_A_STATUS: rd_mux = {29'h0, state_r == st_conv, ot_r, crit_r};
			`RTM_A_INT_ST: rd_mux = {29'h0, int_st_r};
			`RTM_A_INT_EN: rd_mux = {29'h0, int_en_r};
			default: rd_mux = 32'h0;
		endcase
	end

	assign s_axi_arready = !rvalid_r;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= `RTM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= is_mapped(s_axi_araddr) ? `RTM_RESP_OKAY : `RTM_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	property p_crit_set;
		@(posedge i_clk) disable iff (!i_rst_b)
		(!mask_r[`RTM_MK_RCRIT] && over_lim(rem_t_r, crit_lim_r)) |=> !o_critical_alert_out_oe_b;
	endproperty
	a_crit_set: assert property (p_crit_set) else $error("critical alert not driven");

	property p_crit_hold;
		@(posedge i_clk) disable iff (!i_rst_b)
		(crit_r && !mask_r[`RTM_MK_LCRIT] && !below_hyst(loc_t_r, crit_lim_r, hyst_r)) |=> crit_r;
	endproperty
	a_crit_hold: assert property (p_crit_hold) else $error("alert released early");

	property p_ot_hyst;
		@(posedge i_clk) disable iff (!i_rst_b)
		$fell(ot_r) |-> (mask_r[`RTM_MK_ROT] ||
			below_hyst($past(rem_t_r), $past(ot_lim_r), $past(hyst_r)));
	endproperty
	a_ot_hyst: assert property (p_ot_hyst) else $error("overtemp cleared above hysteresis");

	property p_status;
		@(posedge i_clk) disable iff (!i_rst_b)
		(s_axi_arvalid && s_axi_arready && s_axi_araddr == `RTM_A_STATUS) |=>
			(s_axi_rvalid && s_axi_rdata[1:0] == $past({ot_r, crit_r}));
	endproperty
	a_status: assert property (p_status) else $error("status does not show alert levels");

	property p_oneshot;
		@(posedge i_clk) disable iff (!i_rst_b)
		(cfg_r.standby && oneshot_wr && state_r == st_idle) |=> o_conv_start ##1 !o_conv_start;
	endproperty
	a_oneshot: assert property (p_oneshot) else $error("one-shot did not convert once");

	property p_standby;
		@(posedge i_clk) disable iff (!i_rst_b)
		(cfg_r.standby && !oneshot_wr) |=> !o_conv_start;
	endproperty
	a_standby: assert property (p_standby) else $error("conversion started in standby");

	property p_pin_input;
		@(posedge i_clk) disable iff (!i_rst_b)
		!cfg_r.pin_is_overtemp |-> o_overtemp_or_addr_pin_oe_b;
	endproperty
	a_pin_input: assert property (p_pin_input) else $error("shared pin driven as input");

	property p_ot_pin;
		@(posedge i_clk) disable iff (!i_rst_b)
		(cfg_r.pin_is_overtemp && ot_r) |-> (!o_overtemp_or_addr_pin_oe_b && !o_overtemp_or_addr_pin);
	endproperty
	a_ot_pin: assert property (p_ot_pin) else $error("overtemp pin not pulled low");

	property p_uns_fmt;
		@(posedge i_clk) disable iff (!i_rst_b)
		(state_r == st_conv && i_conv_done && cfg_r.unsigned_fmt && i_local_raw < 0)
			|=> loc_res_r == 11'h000;
	endproperty
	a_uns_fmt: assert property (p_uns_fmt) else $error("unsigned format below zero");

endmodule : rtm_monitor

/* tb/rtm_front_model.sv */
// Behavioural analog front end that answers conversion requests after a set delay.
`timescale 1ns/1ps
module rtm_front_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Requests and bench settings
	input wire logic i_start,
	input wire logic [7:0] i_delay,
	input wire logic signed [11:0] i_remote,
	input wire logic signed [11:0] i_local,
	// Results
	output logic o_done,
	output logic signed [11:0] o_remote,
	output logic signed [11:0] o_local
);
	logic [8:0] cnt_r;
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_r <= 9'h0;
			o_done <= 1'b0;
		end else begin
			o_done <= (cnt_r == 9'h1);
			if (i_start) begin
				cnt_r <= {1'b0, i_delay} + 9'h1;
			end else if (cnt_r != 9'h0) begin
				cnt_r <= cnt_r - 9'h1;
			end
		end
	end
	// Results are only valid with the done pulse; at other times they show the inverse.
	assign o_remote = o_done ? i_remote : ~i_remote;
	assign o_local = o_done ? i_local : ~i_local;
endmodule : rtm_front_model

/* tb/test_rtm_monitor.sv */
// Self-checking testbench of the temperature monitor.
`timescale 1ns/1ps
`include "rtm_defs.svh"
module test_rtm_monitor;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [1:0] resp;} rtm_row_t;
	logic i_clk, i_rst_b, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, dly;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, pin_in, addr_sel, rs;
	logic conv_start, conv_done, diode, ot_q, ot_oe_b, crit_q, crit_oe_b, irq;
	logic signed [11:0] rem_raw, loc_raw, rem_v, loc_v;
	int error_cnt = 0, cmp_count = 0, n_start = 0, n_done = 0, n;
	time last_t, prev_t;
	rtm_row_t rows[11] = '{'{0, `RTM_A_CTRL, 32'h0, 2'h0}, '{0, `RTM_A_RATE, 32'hf, 2'h0},
		'{0, `RTM_A_CRIT, 32'h55, 2'h0}, '{0, `RTM_A_OT, 32'h46, 2'h0},
		'{0, `RTM_A_HYST, 32'ha, 2'h0}, '{0, `RTM_A_INT_EN, 32'h0, 2'h0},
		'{0, `RTM_A_ONESHOT, 32'h0, 2'h0}, '{0, 8'h3c, 32'h0, 2'h2}, '{1, 8'h40, 32'h1, 2'h2},
		'{1, `RTM_A_HYST, 32'h5, 2'h0}, '{0, `RTM_A_HYST, 32'h5, 2'h0}};
	rtm_monitor #(.TICK_CYC(8), .TOUT_CYC(16)) DUT (.i_clk(i_clk), .i_rst_b(i_rst_b),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .o_conv_start(conv_start),
		.o_diode_model(diode), .i_conv_done(conv_done), .i_remote_raw(rem_raw),
		.i_local_raw(loc_raw), .i_overtemp_or_addr_pin(pin_in), .o_overtemp_or_addr_pin(ot_q),
		.o_overtemp_or_addr_pin_oe_b(ot_oe_b), .o_critical_alert_out(crit_q),
		.o_critical_alert_out_oe_b(crit_oe_b), .o_addr_select_in(addr_sel), .o_irq(irq));
	rtm_front_model u_front (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(conv_start),
		.i_delay(dly), .i_remote(rem_v), .i_local(loc_v), .o_done(conv_done),
		.o_remote(rem_raw), .o_local(loc_raw));
	always #12.5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		if (conv_start === 1'b1) begin
			n_start++;
			prev_t = last_t;
			last_t = $time;
		end
		if (conv_done === 1'b1) begin
			n_done++;
		end
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ad, wd, ah, wh, bh;
		ad = 0;
		wd = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(negedge i_clk);
			ah = s_axi_awvalid & s_axi_awready;
			wh = s_axi_wvalid & s_axi_wready;
			@(posedge i_clk);
			if (ah) s_axi_awvalid <= 0;
			if (wh) s_axi_wvalid <= 0;
			ad |= ah;
			wd |= wh;
		end while (!(ad && wd));
		do begin
			@(negedge i_clk);
			bh = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge i_clk);
		end while (!bh);
		s_axi_bready <= 0;
		@(posedge i_clk);
	endtask : axi_wr
	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic h;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(negedge i_clk);
			h = s_axi_arready;
			@(posedge i_clk);
		end while (!h);
		s_axi_arvalid <= 0;
		do begin
			@(negedge i_clk);
			h = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge i_clk);
		end while (!h);
		s_axi_rready <= 0;
		@(posedge i_clk);
	endtask : axi_rd
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		axi_rd(a, rd, rs);
		chk(rd, exp);
	endtask : rd_chk
	// One-shot conversion with the given raw values; waits for the result to land.
	task conv(input logic signed [11:0] r, input logic signed [11:0] l);
		rem_v <= r;
		loc_v <= l;
		n = n_done;
		axi_wr(`RTM_A_ONESHOT, 32'h1, rs);
		for (int i = 0; i < 400 && n_done == n; i++) @(posedge i_clk);
		repeat (3) @(posedge i_clk);
	endtask : conv
	task stop_test;
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : stop_test
	initial begin
		#1000000;
		error_cnt++;
		stop_test();
	end
	initial begin
		{i_clk, i_rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 0;
		{s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		s_axi_wstrb = 4'hf;
		{rem_v, loc_v, dly, pin_in} = {12'sd200, 12'sd200, 8'h2, 2'b01};
		repeat (12) @(posedge i_clk);
		i_rst_b <= 1;
		repeat (5) @(posedge i_clk);
		chk(addr_sel, 2'd1);
		chk({ot_oe_b, crit_oe_b, irq}, 3'b110);
		foreach (rows[i]) begin
			if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, rs);
			else axi_rd(rows[i].a, rd, rs);
			chk(rs, rows[i].resp);
			if (!rows[i].wr) chk(rd, rows[i].d);
		end
		axi_wr(`RTM_A_HYST, 32'ha, rs);
		axi_wr(`RTM_A_CTRL, 32'h1, rs);
		n = n_start;
		repeat (300) @(posedge i_clk);
		chk(n_start - n, 0);
		n = n_start;
		conv(12'sd720, 12'sd200);
		chk(n_start - n, 1);
		chk({crit_oe_b, ot_oe_b, ot_q, crit_q}, 4'b0100);
		rd_chk(`RTM_A_STATUS, 32'h3);
		rd_chk(`RTM_A_REMOTE, 32'd720);
		rd_chk(`RTM_A_LOCAL, 32'd200);
		rd_chk(`RTM_A_INT_ST, 32'h7);
		chk(irq, 1'b0);
		axi_wr(`RTM_A_INT_EN, 32'h2, rs);
		chk(irq, 1'b1);
		axi_wr(`RTM_A_INT_CLR, 32'h7, rs);
		rd_chk(`RTM_A_INT_ST, 32'h0);
		chk(irq, 1'b0);
		axi_wr(`RTM_A_CTRL, 32'h9, rs);
		chk(ot_oe_b, 1'b0);
		conv(12'sd600, 12'sd200);
		rd_chk(`RTM_A_STATUS, 32'h3);
		conv(12'sd599, 12'sd200);
		rd_chk(`RTM_A_STATUS, 32'h2);
		chk({crit_oe_b, ot_oe_b}, 2'b10);
		conv(12'sd479, 12'sd200);
		chk({crit_oe_b, ot_oe_b}, 2'b11);
		axi_wr(`RTM_A_HYST, 32'h0, rs);
		conv(12'sd561, 12'sd200);
		chk(ot_oe_b, 1'b0);
		conv(12'sd559, 12'sd200);
		chk(ot_oe_b, 1'b1);
		axi_wr(`RTM_A_HYST, 32'ha, rs);
		axi_wr(`RTM_A_MASK, 32'h5, rs);
		conv(12'sd720, 12'sd200);
		rd_chk(`RTM_A_STATUS, 32'h0);
		conv(12'sd720, 12'sd720);
		rd_chk(`RTM_A_STATUS, 32'h3);
		axi_wr(`RTM_A_OFFSET, 32'h8, rs);
		dly = 8'd60;
		conv(12'sd200, 12'sd200);
		rd_chk(`RTM_A_REMOTE, 32'd208);
		axi_wr(`RTM_A_OFFSET, 32'h0, rs);
		dly = 8'd2;
		conv(12'sh7ff, 12'sd200);
		axi_rd(`RTM_A_REMOTE, rd, rs);
		chk(rd[10:0], 11'h3ff);
		conv(-12'sd16, 12'sd200);
		axi_rd(`RTM_A_REMOTE, rd, rs);
		chk(rd[10:0], 11'h7f0);
		axi_wr(`RTM_A_CTRL, 32'h3, rs);
		conv(12'sh7ff, 12'sd200);
		rd_chk(`RTM_A_REMOTE, 32'h7ff);
		conv(-12'sd16, -12'sd16);
		rd_chk(`RTM_A_REMOTE, 32'h0);
		rd_chk(`RTM_A_LOCAL, 32'h0);
		axi_wr(`RTM_A_CTRL, 32'h15, rs);
		chk(diode, 1'b1);
		conv(12'sd200, 12'sd400);
		rd_chk(`RTM_A_LOCAL, 32'd400);
		axi_wr(`RTM_A_RATE, 32'h1, rs);
		axi_wr(`RTM_A_CTRL, 32'h0, rs);
		n = n_start;
		for (int i = 0; i < 200 && n_start < n + 3; i++) @(posedge i_clk);
		chk(32'(last_t - prev_t), 32'd400);
		s_axi_awaddr <= `RTM_A_HYST;
		s_axi_awvalid <= 1;
		do @(negedge i_clk); while (!s_axi_awready);
		@(posedge i_clk);
		s_axi_awvalid <= 0;
		repeat (24) @(posedge i_clk);
		chk(s_axi_bvalid, 1'b0);
		axi_wr(`RTM_A_HYST, 32'h7, rs);
		rd_chk(`RTM_A_HYST, 32'h7);
		i_rst_b <= 0;
		repeat (3) @(posedge i_clk);
		chk({crit_oe_b, ot_oe_b, irq}, 3'b110);
		i_rst_b <= 1;
		@(posedge i_clk);
		rd_chk(`RTM_A_HYST, 32'ha);
		stop_test();
	end
endmodule : test_rtm_monitor
